/* File: hw/buck_regulator_control_regs.sv */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module buck_regulator_control_regs
   import buck_regs_pkg::*;
   #(parameter int N_BUCK = 2)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // apb slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // fuse words and power state pins
   input wire logic [FUSE_W-1:0] fuse_buck_a_i,
   input wire logic [FUSE_W-1:0] fuse_buck_b_i,
   input wire logic [1:0] op_state_i,
   input wire logic buck_a_sleep_set_i,
   // regulator controls, index 0 is buck a
   output logic config_ready_o,
   output logic [1:0] buck_enable_o,
   output logic [1:0][CODE_W-1:0] buck_code_o,
   output logic [1:0] buck_low_power_o,
   output logic [1:0] buck_slew_select_o,
   output logic [1:0] buck_ccm_ramp_down_o,
   output logic [1:0] buck_forced_pwm_o,
   output logic [1:0] buck_discharge_o,
   output logic [1:0][1:0] buck_current_limit_o,
   output logic [1:0] buck_off_time_o
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (N_BUCK != 2)
   begin : g_bad_count
      $error("register map serves exactly two bucks");
   end

   // ------------------------------------------------------------
   // decoding
   // ------------------------------------------------------------
   function automatic reg_kind_t kind_of(input logic [5:0] idx);
      case (idx)
         IDX_A_RUN_CODE, IDX_B_RUN_CODE: kind_of = K_RUN;
         IDX_A_STBY_CODE, IDX_B_STBY_CODE: kind_of = K_STBY;
         IDX_A_SLEEP_CODE, IDX_B_SLEEP_CODE: kind_of = K_SLEEP;
         IDX_A_CONTROL, IDX_B_CONTROL: kind_of = K_CTRL;
         IDX_A_LIMIT_TIMING, IDX_B_LIMIT_TIMING: kind_of = K_LIM;
         default: kind_of = K_NONE;
      endcase
   endfunction : kind_of

   function automatic logic buck_of(input logic [5:0] idx);
      buck_of = (idx >= IDX_B_RUN_CODE);
   endfunction : buck_of

   function automatic logic [7:0] fuse_ctrl(input logic [FUSE_W-1:0] fz);
      fuse_ctrl = CTRL_RST;
      fuse_ctrl[CTL_RUN_EN] = fz[FZ_RUN_EN];
      fuse_ctrl[CTL_STBY_EN] = fz[FZ_RUN_EN];
      fuse_ctrl[CTL_SLEW] = fz[FZ_SLEW];
      fuse_ctrl[CTL_DIS_N] = fz[FZ_DIS_N];
   endfunction : fuse_ctrl

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int SYNC_W = 2 * FUSE_W + 3;
   logic [SYNC_W-1:0] sync_q;
   logic [FUSE_W-1:0] fuse_s [2];
   logic [1:0] op_s;
   logic set_s;

   sig_sync #(.W(SYNC_W)) u_sync
   (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .d_i({buck_a_sleep_set_i, op_state_i, fuse_buck_b_i, fuse_buck_a_i}),
      .q_o(sync_q)
   );

   assign fuse_s[0] = sync_q[FUSE_W-1:0];
   assign fuse_s[1] = sync_q[2*FUSE_W-1:FUSE_W];
   assign op_s = sync_q[2*FUSE_W+1:2*FUSE_W];
   assign set_s = sync_q[2*FUSE_W+2];

   // ------------------------------------------------------------
   // fuse load sequence
   // ------------------------------------------------------------
   // waits until the synchronised fuse words are valid, then loads once
   load_state_t load_r;
   logic [1:0] wait_r;
   logic load_go;

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         load_r <= LD_WAIT;
         wait_r <= 2'h0;
      end
      else
      begin
         case (load_r)
            LD_WAIT:
            begin
               wait_r <= wait_r + 2'h1;
               if (wait_r == LOAD_WAIT)
                  load_r <= LD_LOAD;
            end
            LD_LOAD: load_r <= LD_DONE;
            LD_DONE: load_r <= LD_DONE;
            default: load_r <= LD_WAIT;
         endcase
      end
   end

   assign load_go = (load_r == LD_LOAD);

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
         config_ready_o <= 1'b0;
      else
         config_ready_o <= (load_r == LD_DONE);
   end

   // ------------------------------------------------------------
   // apb access
   // ------------------------------------------------------------
   logic setup;
   logic hit;
   logic wr_en;
   reg_kind_t kind_d;
   logic buck_d;
   logic [31:0] rd_nxt;
   logic [7:0] ctrl_r [2];
   logic [7:0] lim_r [2];
   logic [CODE_W-1:0] code_r [2][3];

   assign setup = psel_i & ~penable_i;
   assign kind_d = kind_of(paddr_i[7:2]);
   assign buck_d = buck_of(paddr_i[7:2]);
   assign hit = (paddr_i[1:0] == 2'h0) & (kind_d != K_NONE);
   // write lands only at the completing access edge
   assign wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (kind_d)
         K_RUN: rd_nxt[CODE_W-1:0] = code_r[buck_d][0];
         K_STBY: rd_nxt[CODE_W-1:0] = code_r[buck_d][1];
         K_SLEEP: rd_nxt[CODE_W-1:0] = code_r[buck_d][2];
         K_CTRL: rd_nxt[7:0] = ctrl_r[buck_d];
         K_LIM: rd_nxt[7:0] = lim_r[buck_d] & LIM_MASK;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // zero wait states: ready rises in the first access cycle
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         pready_o <= setup;
         // writes before the fuse load would be overwritten, so refuse them
         pslverr_o <= setup & (~hit | (pwrite_i & ~config_ready_o));
         prdata_o <= (setup & ~pwrite_i & hit) ? rd_nxt : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // register storage and per-buck drive
   // ------------------------------------------------------------
   for (genvar b = 0; b < 2; b++)
   begin : g_buck
      logic sel_b;
      assign sel_b = wr_en & (buck_d == 1'(b));

      always_ff @(posedge core_clk_i)
      begin
         if (srst_i)
            ctrl_r[b] <= CTRL_RST;
         else
         begin
            if (load_go)
               ctrl_r[b] <= fuse_ctrl(fuse_s[b]);
            else if (sel_b && kind_d == K_CTRL)
               ctrl_r[b] <= pwdata_i[7:0];
            // external set wins over a clearing write
            if (b == 0 && set_s)
               ctrl_r[b][CTL_SLEEP_EN] <= 1'b1;
         end
      end

      always_ff @(posedge core_clk_i)
      begin
         if (srst_i)
            lim_r[b] <= LIM_RST;
         else if (load_go)
            lim_r[b] <= LIM_RST | {6'h00, fuse_s[b][FZ_ILIM_LO +: 2]};
         else if (sel_b && kind_d == K_LIM)
            lim_r[b] <= pwdata_i[7:0] & LIM_MASK;
      end

      for (genvar k = 0; k < 3; k++)
      begin : g_code
         always_ff @(posedge core_clk_i)
         begin
            if (srst_i)
               code_r[b][k] <= CODE_RST;
            else if (load_go)
               code_r[b][k] <= fuse_s[b][FZ_CODE_LO +: CODE_W];
            else if (sel_b && kind_d == reg_kind_t'(K_RUN + k))
               code_r[b][k] <= pwdata_i[CODE_W-1:0];
         end
      end

      buck_cfg_if cfg ();
      assign cfg.ctrl = ctrl_r[b];
      assign cfg.lim = lim_r[b];
      assign cfg.run_code = code_r[b][0];
      assign cfg.stby_code = code_r[b][1];
      assign cfg.sleep_code = code_r[b][2];
      assign cfg.scale_sel = fuse_s[b][FZ_SCALE_SEL];
      assign cfg.op_state = op_s;

      buck_drive u_drive
      (
         .core_clk_i(core_clk_i),
         .srst_i(srst_i),
         .cfg(cfg),
         .enable_o(buck_enable_o[b]),
         .code_o(buck_code_o[b]),
         .low_power_o(buck_low_power_o[b]),
         .slew_select_o(buck_slew_select_o[b]),
         .ccm_ramp_down_o(buck_ccm_ramp_down_o[b]),
         .forced_pwm_o(buck_forced_pwm_o[b]),
         .discharge_o(buck_discharge_o[b]),
         .current_limit_o(buck_current_limit_o[b]),
         .off_time_o(buck_off_time_o[b])
      );
   end
endmodule : buck_regulator_control_regs

/* File: include/buck_regs_pkg.sv */
// Functional notes
// - ctrl bit 0 enables the buck in run; fuse-loaded, clearing turns it off.
// - ctrl bit 1 enables the buck in standby; loads the run enable fuse.
// - ctrl bit 2 keeps the buck enabled in sleep when 1, off when 0.
// - ctrl bit 3 puts the buck into low power in standby or sleep.
// - ctrl bit 4 slew: 0 is 12.5 mV per 2 us, 1 per 4 us.
// - slew bit loads from fuses, software may change it after power-up.
// - slew bit has no effect when the fuse scaling select is 1.
// - ctrl bit 5 forces continuous conduction while scaling voltage down.
// - ctrl bit 6 forces fixed-frequency pulse-width operation.
// - ctrl bit 7 low connects discharge resistor while the buck is disabled.
// - limit reg bits 1:0 select current limit 1.0/1.2/1.5/2.0 A, fuse-loaded.
// - limit reg bit 4 selects on-time (0) or off-time (1) control, resets 0.
// - buck b run voltage code is 6 bits, loaded from fuses.
// - buck b standby code at 0x39, powers up equal to the run code.
// - buck b sleep code at 0x3a, powers up equal to the run code.
// - fuse-loaded fields start from fuses, then are plain read/write bits.
// - buck a sleep enable also has an external set besides reads and writes.
// - buck b ctrl pair at 0x3b/0x3c mirrors buck a pair at 0x35/0x36.
// - buck a run code at 0x32 fuse-loaded; standby 0x33, sleep 0x34.
package buck_regs_pkg;
   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_A_RUN_CODE = 6'h32;
   localparam logic [5:0] IDX_A_STBY_CODE = 6'h33;
   localparam logic [5:0] IDX_A_SLEEP_CODE = 6'h34;
   localparam logic [5:0] IDX_A_CONTROL = 6'h35;
   localparam logic [5:0] IDX_A_LIMIT_TIMING = 6'h36;
   localparam logic [5:0] IDX_B_RUN_CODE = 6'h38;
   localparam logic [5:0] IDX_B_STBY_CODE = 6'h39;
   localparam logic [5:0] IDX_B_SLEEP_CODE = 6'h3a;
   localparam logic [5:0] IDX_B_CONTROL = 6'h3b;
   localparam logic [5:0] IDX_B_LIMIT_TIMING = 6'h3c;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CODE_W = 6;
   localparam int CTL_RUN_EN = 0;
   localparam int CTL_STBY_EN = 1;
   localparam int CTL_SLEEP_EN = 2;
   localparam int CTL_LOW_PWR = 3;
   localparam int CTL_SLEW = 4;
   localparam int CTL_CCM_DOWN = 5;
   localparam int CTL_FORCED_PWM = 6;
   localparam int CTL_DIS_N = 7;
   localparam int LIM_ILIM_LO = 0;
   localparam int LIM_TIMING = 4;
   localparam logic [7:0] LIM_MASK = 8'h13;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] LIM_RST = 8'h00;
   localparam logic [5:0] CODE_RST = 6'h00;
   // ------------------------------------------------------------
   // fuse word layout, operating state codes, load timing
   // ------------------------------------------------------------
   localparam int FUSE_W = 12;
   localparam int FZ_CODE_LO = 0;
   localparam int FZ_RUN_EN = 6;
   localparam int FZ_SLEW = 7;
   localparam int FZ_DIS_N = 8;
   localparam int FZ_ILIM_LO = 9;
   localparam int FZ_SCALE_SEL = 11;
   localparam logic [1:0] OP_RUN = 2'h0;
   localparam logic [1:0] OP_STBY = 2'h1;
   localparam logic [1:0] OP_SLEEP = 2'h2;
   localparam logic [1:0] LOAD_WAIT = 2'h3;
   typedef enum {K_NONE, K_RUN, K_STBY, K_SLEEP, K_CTRL, K_LIM} reg_kind_t;
   typedef enum {LD_WAIT, LD_LOAD, LD_DONE} load_state_t;
endpackage : buck_regs_pkg

/* File: include/buck_cfg_if.sv */
`timescale 1ns/1ps
interface buck_cfg_if;
   logic [7:0] ctrl;
   logic [7:0] lim;
   logic [5:0] run_code;
   logic [5:0] stby_code;
   logic [5:0] sleep_code;
   logic scale_sel;
   logic [1:0] op_state;
   modport src
   (
      output ctrl, lim, run_code, stby_code, sleep_code, scale_sel, op_state
   );
   modport dst
   (
      input ctrl, lim, run_code, stby_code, sleep_code, scale_sel, op_state
   );
endinterface : buck_cfg_if

/* File: hw/sig_sync.sv */
`timescale 1ns/1ps
module sig_sync
   #(parameter int W = 1)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   // first stage feeds only the second stage
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         meta_r <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : sig_sync

/* File: hw/buck_drive.sv */
`timescale 1ns/1ps
module buck_drive
   import buck_regs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // configuration
   buck_cfg_if.dst cfg,
   // regulator controls
   output logic enable_o,
   output logic [CODE_W-1:0] code_o,
   output logic low_power_o,
   output logic slew_select_o,
   output logic ccm_ramp_down_o,
   output logic forced_pwm_o,
   output logic discharge_o,
   output logic [1:0] current_limit_o,
   output logic off_time_o
);
   logic en_nxt;
   logic [CODE_W-1:0] code_nxt;
   logic quiet_nxt;

   always_comb
   begin
      quiet_nxt = 1'b1;
      case (cfg.op_state)
         OP_STBY:
         begin
            en_nxt = cfg.ctrl[CTL_STBY_EN];
            code_nxt = cfg.stby_code;
         end
         OP_SLEEP:
         begin
            en_nxt = cfg.ctrl[CTL_SLEEP_EN];
            code_nxt = cfg.sleep_code;
         end
         default:
         begin
            // unused state code is treated as run
            en_nxt = cfg.ctrl[CTL_RUN_EN];
            code_nxt = cfg.run_code;
            quiet_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         enable_o <= 1'b0;
         code_o <= CODE_RST;
         low_power_o <= 1'b0;
         slew_select_o <= 1'b0;
         ccm_ramp_down_o <= 1'b0;
         forced_pwm_o <= 1'b0;
         discharge_o <= 1'b0;
         current_limit_o <= 2'h0;
         off_time_o <= 1'b0;
      end
      else
      begin
         enable_o <= en_nxt;
         code_o <= code_nxt;
         low_power_o <= quiet_nxt & cfg.ctrl[CTL_LOW_PWR];
         // fixed ramp selection overrides the slew bit
         slew_select_o <= cfg.ctrl[CTL_SLEW] & ~cfg.scale_sel;
         ccm_ramp_down_o <= cfg.ctrl[CTL_CCM_DOWN];
         forced_pwm_o <= cfg.ctrl[CTL_FORCED_PWM];
         discharge_o <= ~en_nxt & ~cfg.ctrl[CTL_DIS_N];
         current_limit_o <= cfg.lim[LIM_ILIM_LO +: 2];
         off_time_o <= cfg.lim[LIM_TIMING];
      end
   end
endmodule : buck_drive

/* File: tb/buck_regs_asserts.sv */
`timescale 1ns/1ps
module buck_regs_asserts
   import buck_regs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // apb
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // pins and regulator controls
   input wire logic [FUSE_W-1:0] fuse_buck_b_i,
   input wire logic [1:0] op_state_i,
   input wire logic config_ready_o,
   input wire logic [1:0] buck_enable_o,
   input wire logic [1:0] buck_low_power_o,
   input wire logic [1:0] buck_slew_select_o,
   input wire logic [1:0] buck_discharge_o,
   input wire logic [1:0] buck_off_time_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   chk_ready_pulse: assert property (
      psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("ready not a single pulse after setup");
   chk_rdata_idle: assert property (
      !pready_o |-> prdata_o == 32'h0)
      else $error("read data outside answer cycle");
   chk_bad_align: assert property (
      psel_i && !penable_i && paddr_i[1:0] != 2'h0
      |=> pslverr_o && prdata_o == 32'h0)
      else $error("misaligned access not refused");
   chk_early_write: assert property (
      psel_i && !penable_i && pwrite_i && !config_ready_o |=> pslverr_o)
      else $error("write before load not refused");
   chk_ready_holds: assert property (
      config_ready_o |=> config_ready_o)
      else $error("config ready dropped");
   chk_dis_excl: assert property (
      (buck_discharge_o & buck_enable_o) == 2'b00)
      else $error("discharge while enabled");
   chk_low_run: assert property (
      (op_state_i == OP_RUN) [*5] |-> buck_low_power_o == 2'b00)
      else $error("low power in run");
   chk_slew_fuse: assert property (
      fuse_buck_b_i[FZ_SCALE_SEL] [*5] |-> !buck_slew_select_o[1])
      else $error("slew select despite fuse scaling select");
   chk_timing_write: assert property (
      $changed(buck_off_time_o)
      |-> $past(psel_i && penable_i && pwrite_i && pready_o && !pslverr_o, 2))
      else $error("timing output changed without write");
endmodule : buck_regs_asserts

bind buck_regulator_control_regs buck_regs_asserts chk_u
(
   .core_clk_i(core_clk_i),
   .srst_i(srst_i),
   .paddr_i(paddr_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .prdata_o(prdata_o),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .fuse_buck_b_i(fuse_buck_b_i),
   .op_state_i(op_state_i),
   .config_ready_o(config_ready_o),
   .buck_enable_o(buck_enable_o),
   .buck_low_power_o(buck_low_power_o),
   .buck_slew_select_o(buck_slew_select_o),
   .buck_discharge_o(buck_discharge_o),
   .buck_off_time_o(buck_off_time_o)
);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import buck_regs_pkg::*;
   // fuses: a code 15 run on slew 1 dis 0 ilim 2; b code 2a off dis 1 scale 1
   localparam logic [11:0] FUSE_A = 12'h4d5;
   localparam logic [11:0] FUSE_B = 12'hb2a;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, config_ready_o, err;
   logic [1:0] op_state_i = OP_RUN;
   logic buck_a_sleep_set_i = 1'b0;
   logic [1:0] en_o, lp_o, slew_o, ccm_o, forced_pulse_width_o, dis_o, off_o;
   logic [1:0][CODE_W-1:0] code_o;
   logic [1:0][1:0] ilim_o;
   int errors = 0, n_tests = 0, cycles = 0;
   logic [5:0] idx_t [10] = '{IDX_A_RUN_CODE, IDX_A_STBY_CODE,
      IDX_A_SLEEP_CODE, IDX_A_CONTROL, IDX_A_LIMIT_TIMING, IDX_B_RUN_CODE,
      IDX_B_STBY_CODE, IDX_B_SLEEP_CODE, IDX_B_CONTROL, IDX_B_LIMIT_TIMING};
   logic [7:0] rst_t [10] = '{8'h15, 8'h15, 8'h15, 8'h13, 8'h02,
      8'h2a, 8'h2a, 8'h2a, 8'h80, 8'h01};

   buck_regulator_control_regs #(.N_BUCK(2)) dut_u (.core_clk_i(core_clk_i),
      .srst_i(srst_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .fuse_buck_a_i(FUSE_A), .fuse_buck_b_i(FUSE_B),
      .op_state_i(op_state_i), .buck_a_sleep_set_i(buck_a_sleep_set_i),
      .config_ready_o(config_ready_o), .buck_enable_o(en_o),
      .buck_code_o(code_o), .buck_low_power_o(lp_o),
      .buck_slew_select_o(slew_o), .buck_ccm_ramp_down_o(ccm_o),
      .buck_forced_pwm_o(forced_pulse_width_o), .buck_discharge_o(dis_o),
      .buck_current_limit_o(ilim_o), .buck_off_time_o(off_o));

   always #12.5 core_clk_i = ~core_clk_i;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         end_sim();
      end
   end
   task end_sim();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   // reads sample before the edge's updates land, so no race
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      k = 0;
      @(posedge core_clk_i);
      while (pready_o !== 1'b1 && k < 20)
      begin
         @(posedge core_clk_i);
         k++;
      end
      if (k == 20)
      begin
         errors++;
         end_sim();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : apb
   task wr(input logic [5:0] i, input logic [7:0] d);
      apb(1'b1, {i, 2'b00}, d);
   endtask : wr
   task rdchk(input logic [5:0] i, input logic [7:0] e);
      apb(1'b0, {i, 2'b00}, 8'h00);
      chk(rd, {24'h0, e}, "register read back");
      chk(err, 1'b0, "read refused");
   endtask : rdchk
   // outputs lag pins by three edges
   task settle();
      repeat (5) @(posedge core_clk_i);
   endtask : settle
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_load();
      int k;
      wr(IDX_A_CONTROL, 8'h00);
      chk(err, 1'b1, "early write accepted");
      k = 0;
      while (config_ready_o !== 1'b1 && k < 50)
      begin
         @(posedge core_clk_i);
         k++;
      end
      chk(config_ready_o, 1'b1, "fuse load done");
      for (int i = 0; i < 10; i++)
         rdchk(idx_t[i], rst_t[i]);
      chk(en_o, 2'b01, "run enables");
      chk(code_o, {6'h2a, 6'h15}, "run codes");
      chk(slew_o, 2'b01, "slew after load");
      chk(ilim_o, 4'h6, "current limits");
   endtask : t_load
   task t_fields();
      wr(IDX_A_CONTROL, 8'h78);
      rdchk(IDX_A_CONTROL, 8'h78);
      settle();
      chk({en_o[0], dis_o[0], lp_o[0]}, 3'b010, "run off");
      chk({slew_o[0], ccm_o[0], forced_pulse_width_o[0]}, 3'b111, "mode bits");
      op_state_i <= OP_STBY;
      settle();
      chk(lp_o[0], 1'b1, "low power in standby");
   endtask : t_fields
   task t_states();
      wr(IDX_B_STBY_CODE, 8'h11);
      wr(IDX_B_SLEEP_CODE, 8'h22);
      wr(IDX_B_CONTROL, 8'h06);
      for (int s = 0; s < 4; s++)
      begin
         op_state_i <= s[1:0];
         settle();
         chk(en_o[1], s == 1 || s == 2, "state enable");
         chk(dis_o[1], !(s == 1 || s == 2), "discharge");
         chk(code_o[1], s == 1 ? 6'h11 : s == 2 ? 6'h22 : 6'h2a, "code");
      end
      wr(IDX_B_CONTROL, 8'h12);
      op_state_i <= OP_SLEEP;
      settle();
      chk(en_o[1], 1'b0, "sleep disabled");
      chk(slew_o[1], 1'b0, "slew ignored");
      rdchk(IDX_B_CONTROL, 8'h12);
      op_state_i <= OP_RUN;
   endtask : t_states
   task t_limit();
      wr(IDX_A_LIMIT_TIMING, 8'hff);
      rdchk(IDX_A_LIMIT_TIMING, 8'h13);
      wr(IDX_B_LIMIT_TIMING, 8'h10);
      settle();
      chk({ilim_o, off_o}, 6'b001111, "limit and timing");
   endtask : t_limit
   task t_bad_addr();
      apb(1'b1, 8'hdc, 8'hff);
      chk(err, 1'b1, "unmapped write");
      chk(rd, 32'h0000_0000, "unmapped write data");
      apb(1'b0, {IDX_A_CONTROL, 2'b01}, 8'h00);
      chk(err, 1'b1, "misaligned read");
      chk(rd, 32'h0000_0000, "misaligned read data");
   endtask : t_bad_addr
   task t_sleep_set();
      buck_a_sleep_set_i <= 1'b1;
      settle();
      wr(IDX_A_CONTROL, 8'h00);
      rdchk(IDX_A_CONTROL, 8'h04);
      buck_a_sleep_set_i <= 1'b0;
      settle();
      wr(IDX_A_CONTROL, 8'h00);
      rdchk(IDX_A_CONTROL, 8'h00);
   endtask : t_sleep_set

   initial
   begin
      repeat (8) @(posedge core_clk_i);
      srst_i <= 1'b0;
      t_load();
      t_fields();
      t_states();
      t_limit();
      t_bad_addr();
      t_sleep_set();
      end_sim();
   end
endmodule : testbench
